// ==== psc_chan_seq.sv ====
// Purpose: On/off sequencing of one PWM channel under its policy byte.
// Assumes: ms_tick_in is a one-cycle pulse each millisecond; delays are in ms.
// Notes:   The run pin pulse counter runs apart from the state so it can outlast the turn-off delay and fall time.
`include "psc_defines.svh"
module psc_chan_seq (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   // Timing
   input  wire logic        ms_tick_in,
   input  wire logic [15:0] turn_off_delay_ms_in,
   input  wire logic [15:0] turn_off_fall_time_ms_in,
   input  wire logic [15:0] restart_ms_in,
   // Control
   input  wire logic        on_req_in,
   input  wire logic [7:0]  policy_in,
   input  wire logic        shclk_low_in,
   input  wire logic        decayed_in,
   // Status
   output logic             enable_out,
   output logic             running_out,
   output logic             run_low_out
);
   typedef enum logic [4:0] {
      PSC_OFF   = 5'b00001,
      PSC_ON    = 5'b00010,
      PSC_DELAY = 5'b00100,
      PSC_FALL  = 5'b01000,
      PSC_HOLD  = 5'b10000
   } psc_seq_t;

   psc_seq_t    state;
   psc_seq_t    next_state;
   logic [17:0] tmr;
   logic [17:0] next_tmr;
   logic [17:0] pulse;
   logic [17:0] next_pulse;
   logic [17:0] pulse_len;

   always_comb begin
      pulse_len = {2'b00, turn_off_delay_ms_in} + {2'b00, turn_off_fall_time_ms_in}
                  + 18'(`PSC_RUN_EXTRA_MS);
      if ({2'b00, restart_ms_in} > pulse_len) begin
         pulse_len = {2'b00, restart_ms_in};
      end
      next_state = state;
      next_tmr   = tmr;
      next_pulse = pulse;
      if (ms_tick_in && tmr != 18'h00000) begin
         next_tmr = tmr - 18'h00001;
      end
      if (ms_tick_in && pulse != 18'h00000) begin
         next_pulse = pulse - 18'h00001;
      end
      unique case (state)
         PSC_OFF: begin
            // Restart waits for the run pulse and, unless waived, for output decay.
            if (on_req_in && pulse == 18'h00000 &&
                (policy_in[`PSC_CC_NO_DECAY] || decayed_in)) begin
               next_state = PSC_ON;
            end
         end
         PSC_ON: begin
            if (!on_req_in) begin
               next_state = PSC_DELAY;
               next_tmr   = {2'b00, turn_off_delay_ms_in};
               if (!policy_in[`PSC_CC_RUN_NOPULSE]) begin
                  next_pulse = pulse_len;
               end
            end
         end
         PSC_DELAY, PSC_FALL: begin
            if (on_req_in) begin
               if (policy_in[`PSC_CC_SHORT_CYCLE]) begin
                  next_state = PSC_HOLD;
                  next_tmr   = 18'(`PSC_MIN_OFF_MS);
               end else begin
                  next_state = PSC_ON;
               end
            end else if (tmr == 18'h00000) begin
               if (state == PSC_DELAY) begin
                  next_state = PSC_FALL;
                  next_tmr   = {2'b00, turn_off_fall_time_ms_in};
               end else begin
                  next_state = PSC_OFF;
               end
            end
         end
         PSC_HOLD: begin
            if (tmr == 18'h00000) begin
               next_state = PSC_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state <= PSC_OFF;
         tmr   <= 18'h00000;
         pulse <= 18'h00000;
      end else begin
         state <= next_state;
         tmr   <= next_tmr;
         pulse <= next_pulse;
      end
   end

   always_comb begin
      running_out = (state == PSC_ON) || (state == PSC_DELAY) || (state == PSC_FALL);
      enable_out  = running_out && !(policy_in[`PSC_CC_SHCLK_GATE] && shclk_low_in);
      run_low_out = pulse != 18'h00000;
   end
endmodule // psc_chan_seq

// ==== psc_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the PWM config block.
// Assumes: A 100 MHz system clock.
// Notes:   Included by the design modules and by the checker.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_CMD_SHARED_CLK   8'hF5
`define PSC_CMD_CHAN_POLICY  8'hD0
`define PSC_PAGE_ALL         8'hFF
`define PSC_SHARED_RESET     8'h14
`define PSC_CHAN_RESET       8'h1D
`define PSC_SHARED_MASK      8'h17
`define PSC_CHAN_MASK        8'h1D
`define PSC_SC_SHCLK_MODE    4
`define PSC_CC_RUN_NOPULSE   4
`define PSC_CC_SHORT_CYCLE   3
`define PSC_CC_SHCLK_GATE    2
`define PSC_CC_NO_DECAY      0
`define PSC_RUN_EXTRA_MS     136
`define PSC_MIN_OFF_MS       120
`define PSC_MS_NS            1000000
`define PSC_CLK_NS           10
`define PSC_MS_CYCLES        (`PSC_MS_NS / `PSC_CLK_NS)

`endif

// ==== psc_far_side.sv ====
// Purpose: Far side of the block: peer controllers on the shared clock line and output rails.
// Assumes: The line has a pull-up; a rail decays DECAY_CYCLES after its channel stops.
// Notes:   decay_stall_in models a rail that discharges too slowly.
module psc_far_side #(
   parameter int DECAY_CYCLES = 20
) (
   // Clock
   input  wire logic       clk_sys_in,
   // Shared clock line
   input  wire logic       line_oe_n_in,
   input  wire logic       peer_hold_in,
   output logic            line_out,
   // Output rails
   input  wire logic [1:0] enable_in,
   input  wire logic       decay_stall_in,
   output logic [1:0]      decayed_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [2] = '{0, 0};
   // Any party may hold the line low; released by all, the pull-up wins.
   assign line_out = line_oe_n_in && !peer_hold_in;
   always @(posedge clk_sys_in) begin
      for (int i = 0; i < 2; i++) begin
         cnt[i] <= enable_in[i] ? 0 : cnt[i] + (cnt[i] < DECAY_CYCLES);
      end
   end
   assign decayed_out[0] = cnt[0] >= DECAY_CYCLES && !decay_stall_in;
   assign decayed_out[1] = cnt[1] >= DECAY_CYCLES && !decay_stall_in;
endmodule  // psc_far_side

// ==== psc_pkg.sv ====
// Purpose: Types shared by the PWM config block.
// Assumes: psc_defines.svh supplies the numbers.
// Notes:   Command strobe and phase decode travel as packed structs.
package psc_pkg;
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] code;
      logic [7:0] page;
      logic [7:0] data;
   } psc_cmd_t;

   typedef struct packed {
      logic [8:0] ch0_deg;
      logic [8:0] ch1_deg;
      logic [9:0] max_duty_permille;
   } psc_phase_t;
endpackage

// ==== psc_pwm_config.sv ====
// Purpose: Shared clocking and per-channel on/off policy bytes of a dual PWM controller.
// Assumes: A bus engine delivers decoded command bytes; comparator flags are asynchronous.
// Notes:   Open-drain pins use active-low output enables; the pin level driven is always 0.
`include "psc_defines.svh"

module psc_pwm_config #(
   parameter int MS_TICK_CYCLES = `PSC_MS_CYCLES
) (
   // Clock and reset
   input  wire logic                 clk_sys_in,
   input  wire logic                 sys_rst_in,
   // Command port from the bus engine
   input  wire psc_pkg::psc_cmd_t    cmd_in,
   output logic                      cmd_ack_out,
   output logic [7:0]                cmd_rdata_out,
   output logic                      busy_fault_out,
   // Channel requests and timing
   input  wire logic [1:0]           on_req_in,
   input  wire logic [15:0]          turn_off_delay_ms_in,
   input  wire logic [15:0]          turn_off_fall_time_ms_in,
   input  wire logic [15:0]          restart_ms_in,
   // Analog comparator flags
   input  wire logic                 vin_at_start_in,
   input  wire logic                 vin_at_stop_in,
   input  wire logic [1:0]           out_decayed_in,
   // Shared clock line, open drain
   input  wire logic                 shared_clock_line_in,
   output logic                      shared_clock_line_out,
   output logic                      shared_clock_line_oe_n_out,
   // Run pins, open drain
   output logic [1:0]                channel_run_pin_out,
   output logic [1:0]                channel_run_pin_oe_n_out,
   // Channel outputs and configuration
   output logic [1:0]                channel_enable_out,
   output psc_pkg::psc_phase_t       phase_out,
   output logic [7:0]                shared_clocking_config_out
);
   import psc_pkg::*;

   function automatic psc_phase_t psc_decode_phase(input logic [2:0] code);
      psc_phase_t p;
      p.max_duty_permille = code[2] ? 10'h36B : 10'h341;
      unique case (code)
         3'b111: begin
            p.ch0_deg = 9'h087;
            p.ch1_deg = 9'h13B;
         end
         3'b110: begin
            p.ch0_deg = 9'h05A;
            p.ch1_deg = 9'h10E;
         end
         3'b101: begin
            p.ch0_deg = 9'h02D;
            p.ch1_deg = 9'h0E1;
         end
         3'b100: begin
            p.ch0_deg = 9'h000;
            p.ch1_deg = 9'h0B4;
         end
         3'b011: begin
            p.ch0_deg = 9'h078;
            p.ch1_deg = 9'h12C;
         end
         3'b010: begin
            p.ch0_deg = 9'h03C;
            p.ch1_deg = 9'h0F0;
         end
         3'b001: begin
            p.ch0_deg = 9'h000;
            p.ch1_deg = 9'h0B4;
         end
         3'b000: begin
            p.ch0_deg = 9'h000;
            p.ch1_deg = 9'h078;
         end
      endcase
      return p;
   endfunction

   function automatic logic psc_page_hits(input logic [7:0] page, input int ch);
      return (page == `PSC_PAGE_ALL) || (page == 8'(ch));
   endfunction

   logic [4:0]  sync_bits;
   logic        vin_start_s;
   logic        vin_stop_s;
   logic        shclk_low;
   logic [1:0]  decayed_s;
   logic [16:0] div_cnt;
   logic [16:0] next_div_cnt;
   logic        ms_tick;
   logic        next_ms_tick;
   logic [7:0]  shared_cfg;
   logic [7:0]  next_shared_cfg;
   logic [7:0]  policy       [2];
   logic [7:0]  next_policy  [2];
   logic [7:0]  next_rdata;
   logic        next_busy;
   logic        shclk_hold;
   logic        next_shclk_hold;
   logic [1:0]  running;
   logic [1:0]  run_low;
   logic        code_known;
   logic        shared_blocked;
   logic [7:0]  read_value;
   int          rd_ch;
   psc_phase_t  next_phase;

   psc_sync #(
      .WIDTH (5)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .async_in   ({vin_at_start_in, vin_at_stop_in, shared_clock_line_in, out_decayed_in}),
      .sync_out   (sync_bits)
   );

   always_comb begin
      vin_start_s = sync_bits[4];
      vin_stop_s  = sync_bits[3];
      shclk_low   = !sync_bits[2];
      decayed_s   = sync_bits[1:0];
   end

   // Millisecond enable for the channel timers.
   always_comb begin
      next_ms_tick = 1'b0;
      next_div_cnt = div_cnt + 17'h00001;
      if (div_cnt == 17'(MS_TICK_CYCLES - 1)) begin
         next_div_cnt = 17'h00000;
         next_ms_tick = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         div_cnt <= 17'h00000;
         ms_tick <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         ms_tick <= next_ms_tick;
      end
   end

   // Command decode and register file.
   always_comb begin
      code_known     = (cmd_in.code == `PSC_CMD_SHARED_CLK) ||
                       (cmd_in.code == `PSC_CMD_CHAN_POLICY);
      shared_blocked = cmd_in.write && (cmd_in.code == `PSC_CMD_SHARED_CLK) &&
                       (running != 2'b00);
      cmd_ack_out    = cmd_in.valid && code_known && !shared_blocked;
      rd_ch          = (cmd_in.page == 8'h01) ? 1 : 0;
      read_value     = (cmd_in.code == `PSC_CMD_SHARED_CLK) ? shared_cfg :
                       (cmd_in.code == `PSC_CMD_CHAN_POLICY) ? policy[rd_ch] : 8'h00;
      next_shared_cfg = shared_cfg;
      next_rdata      = cmd_rdata_out;
      next_busy       = cmd_in.valid && shared_blocked;
      for (int ch = 0; ch < 2; ch++) begin
         next_policy[ch] = policy[ch];
      end
      if (cmd_in.valid && !cmd_in.write) begin
         next_rdata = read_value;
      end
      if (cmd_ack_out && cmd_in.write) begin
         if (cmd_in.code == `PSC_CMD_SHARED_CLK) begin
            next_shared_cfg = cmd_in.data & `PSC_SHARED_MASK;
         end else begin
            for (int ch = 0; ch < 2; ch++) begin
               if (psc_page_hits(cmd_in.page, ch)) begin
                  next_policy[ch] = cmd_in.data & `PSC_CHAN_MASK;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         shared_cfg     <= `PSC_SHARED_RESET;
         cmd_rdata_out  <= 8'h00;
         busy_fault_out <= 1'b0;
         for (int ch = 0; ch < 2; ch++) begin
            policy[ch] <= `PSC_CHAN_RESET;
         end
      end else begin
         shared_cfg     <= next_shared_cfg;
         cmd_rdata_out  <= next_rdata;
         busy_fault_out <= next_busy;
         for (int ch = 0; ch < 2; ch++) begin
            policy[ch] <= next_policy[ch];
         end
      end
   end

   // The line starts held low so no paralleled part clocks before input is good.
   always_comb begin
      next_shclk_hold = shclk_hold;
      if (vin_start_s) begin
         next_shclk_hold = 1'b0;
      end else if (shared_cfg[`PSC_SC_SHCLK_MODE] && vin_stop_s) begin
         next_shclk_hold = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         shclk_hold <= 1'b1;
      end else begin
         shclk_hold <= next_shclk_hold;
      end
   end

   always_comb begin
      next_phase = psc_decode_phase(shared_cfg[2:0]);
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         phase_out <= '0;
      end else begin
         phase_out <= next_phase;
      end
   end

   always_comb begin
      shared_clock_line_out      = 1'b0;
      shared_clock_line_oe_n_out = !shclk_hold;
      shared_clocking_config_out = shared_cfg;
   end

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      psc_chan_seq u_seq (
         .clk_sys_in       (clk_sys_in),
         .sys_rst_in       (sys_rst_in),
         .ms_tick_in       (ms_tick),
         .turn_off_delay_ms_in (turn_off_delay_ms_in),
         .turn_off_fall_time_ms_in  (turn_off_fall_time_ms_in),
         .restart_ms_in    (restart_ms_in),
         .on_req_in        (on_req_in[ch]),
         .policy_in        (policy[ch]),
         .shclk_low_in     (shclk_low),
         .decayed_in       (decayed_s[ch]),
         .enable_out       (channel_enable_out[ch]),
         .running_out      (running[ch]),
         .run_low_out      (run_low[ch])
      );
      always_comb begin
         channel_run_pin_out[ch]      = 1'b0;
         channel_run_pin_oe_n_out[ch] = !run_low[ch];
      end
   end
endmodule // psc_pwm_config

// ==== psc_pwm_config_checker.sv ====
// Purpose: Port-level assertions of the PWM config block.
// Assumes: Sees only ports of psc_pwm_config; policy bytes stay inside.
// Notes:   Channel timing is judged by the bench, since policy is not visible here.
`include "psc_defines.svh"
module psc_pwm_config_checker #(
   parameter int MS_TICK_CYCLES = 10
) (
   input wire logic                clk_sys_in,
   input wire logic                sys_rst_in,
   input wire psc_pkg::psc_cmd_t   cmd_in,
   input wire logic                cmd_ack_out,
   input wire logic [7:0]          cmd_rdata_out,
   input wire logic                busy_fault_out,
   input wire logic                vin_at_start_in,
   input wire logic                vin_at_stop_in,
   input wire logic                shared_clock_line_oe_n_out,
   input wire logic [1:0]          channel_enable_out,
   input wire logic [7:0]          shared_clocking_config_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import psc_pkg::*;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   logic wr_sh;
   logic refused;
   logic [7:0] cfg;
   assign cfg = shared_clocking_config_out;
   assign wr_sh = cmd_in.valid && cmd_in.write && cmd_in.code == `PSC_CMD_SHARED_CLK;
   assign refused = wr_sh && !cmd_ack_out;
   property p_nack_run;
      wr_sh && (|channel_enable_out) |-> !cmd_ack_out;
   endproperty
   a_nack_run: assert property (p_nack_run) else $error("shared write taken while running");
   property p_busy_after;
      refused |=> busy_fault_out;
   endproperty
   a_busy_after: assert property (p_busy_after) else $error("no busy after refusal");
   property p_busy_cause;
      busy_fault_out |-> $past(refused);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without refusal");
   property p_discard;
      refused |=> $stable(cfg);
   endproperty
   a_discard: assert property (p_discard) else $error("refused data stored");
   property p_store;
      wr_sh && cmd_ack_out |=> cfg == ($past(cmd_in.data) & `PSC_SHARED_MASK);
   endproperty
   a_store: assert property (p_store) else $error("shared byte not stored");
   property p_rd_shared;
      cmd_in.valid && !cmd_in.write && cmd_in.code == `PSC_CMD_SHARED_CLK
         |=> cmd_rdata_out == $past(cfg);
   endproperty
   a_rd_shared: assert property (p_rd_shared) else $error("shared read wrong");
   property p_line_release;
      vin_at_start_in [*5] |-> shared_clock_line_oe_n_out;
   endproperty
   a_line_release: assert property (p_line_release) else $error("line not released");
   property p_line_keep;
      !cfg[4] && shared_clock_line_oe_n_out |=> shared_clock_line_oe_n_out;
   endproperty
   a_line_keep: assert property (p_line_keep) else $error("line re-held in mode 0");
   property p_line_force;
      (cfg[4] && vin_at_stop_in && !vin_at_start_in) [*5] |-> !shared_clock_line_oe_n_out;
   endproperty
   a_line_force: assert property (p_line_force) else $error("line not forced low");
   c_refused: cover property (refused);
   c_forced: cover property (cfg[4] && !shared_clock_line_oe_n_out);
   c_chan_on: cover property (|channel_enable_out);
endmodule  // psc_pwm_config_checker

bind psc_pwm_config psc_pwm_config_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_chk (.*);

// ==== psc_pwm_config_tb.sv ====
// Purpose: Self-checking bench of the PWM config block.
// Assumes: A tick every 10 cycles, so a count of N ms lasts about 10*N cycles.
// Notes:   Channel 0 timing is measured; channel 1 only serves the policy read-back and busy cases.
module psc_pwm_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import psc_pkg::*;
   logic        clk_sys_in, sys_rst_in, a_s, b_s, ack, busy, line, peer, stall;
   logic        vstart, vstop, line_oe_n, line_lvl;
   logic [1:0]  on_req, en, run_oe_n, dec, run_pin;
   logic [7:0]  r_s, rdata, cfg;
   logic [15:0] restart;
   psc_cmd_t    cmd;
   psc_phase_t  ph;
   int          fails, checks, cyc, n;
   int          rs [2] = '{1, 200};
   int          pl [2] = '{140, 200};
   // Rows: byte written, channel 0 and 1 degrees, max duty (0 means unchecked).
   // Bits 5 and 3 are set now and then to see reserved bits dropped.
   logic [35:0] rows [8] = '{
      {8'h2F, 9'h087, 9'h13B, 10'h36B}, {8'h06, 9'h05A, 9'h10E, 10'h36B},
      {8'h1D, 9'h02D, 9'h0E1, 10'h36B}, {8'h10, 9'h000, 9'h078, 10'h000},
      {8'h3B, 9'h078, 9'h12C, 10'h341}, {8'h02, 9'h03C, 9'h0F0, 10'h341},
      {8'h09, 9'h000, 9'h0B4, 10'h341}, {8'h04, 9'h000, 9'h0B4, 10'h36B}};

   psc_pwm_config #(.MS_TICK_CYCLES(10)) dut (
      .clk_sys_in, .sys_rst_in, .cmd_in(cmd), .cmd_ack_out(ack), .cmd_rdata_out(rdata),
      .busy_fault_out(busy), .on_req_in(on_req), .turn_off_delay_ms_in(16'h0002),
      .turn_off_fall_time_ms_in(16'h0002), .restart_ms_in(restart), .vin_at_start_in(vstart),
      .vin_at_stop_in(vstop), .out_decayed_in(dec), .shared_clock_line_in(line),
      .shared_clock_line_out(line_lvl), .shared_clock_line_oe_n_out(line_oe_n),
      .channel_run_pin_out(run_pin), .channel_run_pin_oe_n_out(run_oe_n),
      .channel_enable_out(en), .phase_out(ph), .shared_clocking_config_out(cfg));
   psc_far_side #(.DECAY_CYCLES(20)) far (.clk_sys_in, .line_oe_n_in(line_oe_n),
      .peer_hold_in(peer), .line_out(line), .enable_in(en), .decay_stall_in(stall),
      .decayed_out(dec));

   task automatic stop_test;
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] c, p, d);
      @(posedge clk_sys_in);
      #1 cmd = '{1'b1, w, c, p, d};
      @(posedge clk_sys_in);
      a_s = ack;
      #1 cmd.valid = 1'b0;
      r_s = rdata;
      b_s = busy;
   endtask
   task automatic wr(input logic [7:0] c, p, d);
      bus(1'b1, c, p, d);
      chk("ack", a_s, 1'b1);
   endtask
   task automatic rd(input logic [7:0] c, p, e);
      bus(1'b0, c, p, 8'h00);
      chk("rdata", r_s, e);
   endtask
   // Waits for enable, run pin enable or line enable to reach v; k is cycles spent.
   task automatic wt(input int s, input logic v, input int mx, output int k);
      for (k = 0; k < mx; k++) begin
         @(posedge clk_sys_in);
         #1;
         if ((s == 0 ? en[0] : s == 1 ? run_oe_n[0] : line_oe_n) === v) break;
      end
   endtask

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end

   initial begin
      sys_rst_in = 1'b1;
      cmd = '0;
      on_req = 2'b00;
      {vstart, vstop, peer, stall} = 4'h0;
      restart = 16'h0001;
      repeat (4) @(posedge clk_sys_in);
      #1 sys_rst_in = 1'b0;
      chk("cfg", cfg, 8'h14);
      chk("line", line_oe_n, 1'b0);
      chk("pins", {line_lvl, run_pin}, 3'h0);
      rd(8'hF5, 8'h00, 8'h14);
      rd(8'hD0, 8'h01, 8'h1D);
      vstart = 1'b1;
      wt(2, 1'b1, 10, n);
      chk("start", n < 10, 1'b1);
      foreach (rows[i]) begin
         wr(8'hF5, 8'h00, rows[i][35:28]);
         rd(8'hF5, 8'h00, rows[i][35:28] & 8'h17);
         chk("ch0", ph.ch0_deg, rows[i][27:19]);
         chk("ch1", ph.ch1_deg, rows[i][18:10]);
         if (rows[i][9:0] != 10'h000) chk("duty", ph.max_duty_permille, rows[i][9:0]);
      end
      {vstart, vstop} = 2'b01;
      wt(2, 1'b0, 10, n);
      chk("keep", n, 10);
      wr(8'hF5, 8'h00, 8'h14);
      wt(2, 1'b0, 10, n);
      chk("force", n < 6, 1'b1);
      {vstart, vstop} = 2'b10;
      wt(2, 1'b1, 10, n);
      chk("rel", n < 6, 1'b1);
      wr(8'hD0, 8'h01, 8'h2D);
      rd(8'hD0, 8'h01, 8'h0D);
      rd(8'hD0, 8'h00, 8'h1D);
      on_req = 2'b10;
      repeat (3) @(posedge clk_sys_in);
      bus(1'b1, 8'hF5, 8'h00, 8'h07);
      chk("nack", a_s, 1'b0);
      chk("busy", b_s, 1'b1);
      chk("kept", cfg, 8'h14);
      on_req = 2'b00;
      wr(8'hD0, 8'h00, 8'h15);
      on_req[0] = 1'b1;
      wt(0, 1'b1, 5, n);
      chk("on", n, 0);
      peer = 1'b1;
      wt(0, 1'b0, 8, n);
      chk("gate", n < 5, 1'b1);
      peer = 1'b0;
      wt(0, 1'b1, 8, n);
      chk("ungate", n < 5, 1'b1);
      wr(8'hD0, 8'h00, 8'h11);
      peer = 1'b1;
      wt(0, 1'b0, 10, n);
      chk("nogate", n, 10);
      peer = 1'b0;
      on_req[0] = 1'b0;
      repeat (5) @(posedge clk_sys_in);
      #1 on_req[0] = 1'b1;
      wt(0, 1'b0, 100, n);
      chk("follow", n, 100);
      wr(8'hD0, 8'h00, 8'h19);
      on_req[0] = 1'b0;
      repeat (5) @(posedge clk_sys_in);
      #1 on_req[0] = 1'b1;
      wt(0, 1'b0, 3, n);
      chk("cut", n < 2, 1'b1);
      wt(0, 1'b1, 1400, n);
      chk("hold", n >= 1185 && n <= 1225, 1'b1);
      wr(8'hD0, 8'h00, 8'h11);
      on_req[0] = 1'b0;
      wt(1, 1'b0, 100, n);
      chk("nopulse", n, 100);
      stall = 1'b1;
      on_req[0] = 1'b1;
      wt(0, 1'b1, 5, n);
      chk("nodecay", n < 3, 1'b1);
      on_req[0] = 1'b0;
      wr(8'hD0, 8'h00, 8'h10);
      wt(0, 1'b0, 60, n);
      on_req[0] = 1'b1;
      wt(0, 1'b1, 60, n);
      chk("decay", n, 60);
      stall = 1'b0;
      wt(0, 1'b1, 10, n);
      chk("retry", n < 6, 1'b1);
      wr(8'hD0, 8'h00, 8'h01);
      foreach (rs[k]) begin
         restart = rs[k][15:0];
         on_req[0] = 1'b1;
         wt(0, 1'b1, 5, n);
         on_req[0] = 1'b0;
         wt(1, 1'b0, 3, n);
         chk("pstart", n < 2, 1'b1);
         wt(1, 1'b1, 2500, n);
         chk("pulse", n >= pl[k] * 10 - 12 && n <= pl[k] * 10 + 12, 1'b1);
      end
      // A reset with channel 0 idle and its run pulse over must bring back the defaults and hold the line again.
      sys_rst_in = 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1 sys_rst_in = 1'b0;
      chk("rst_line", line_oe_n, 1'b0);
      chk("rst_run", {run_oe_n, en}, 4'hC);
      rd(8'hD0, 8'h00, 8'h1D);
      wt(2, 1'b1, 10, n);
      chk("rst_start", n < 6, 1'b1);
      stop_test();
   end
endmodule  // psc_pwm_config_tb

// ==== psc_sync.sv ====
// Purpose: Two-flop synchroniser for asynchronous levels.
// Assumes: Inputs are slow levels from pins or analog comparators.
// Notes:   The first stage feeds only the second.
module psc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             sys_rst_in,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync;

   always_comb begin
      next_stage1 = async_in;
      next_sync   = stage1;
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= next_stage1;
         sync_out <= next_sync;
      end
   end
endmodule // psc_sync
